/* File: hdl/lks_link_stack.sv */
// Link stack, level counter and program counter of the core sequencer
`include "lks_map.svh"
// Contract
// - Counter past 1fff wraps to 0000 in the same code half.
// - Code half changes only on indirect jump, service entry, interrupt, return or reset.
// - Sixteen 16-bit slot addresses, only slots 0 to 14 store.
// - Four-bit binary level counter selects the slot directly.
// - Register instructions read and write the level counter at address 01.
// - Slot 15 reads as zero; software must avoid level 15 access.
// - All resets set counter to 1111; clock stop holds it.
// - Call: decrement level, then store next address in slot.
// - Return: load counter from slot, then increment level.
// - Table read uses one level, fetches word, restores counter, increments.
// - Interrupt pushes like call but saves the current address; interrupt return pops like return.
// - Pointer save: decrement level, copy pointer word into slot.
// - Pointer restore: copy slot into pointer word, increment level.
// - Service entry: decrement, store address and code half bit.
// - Return after service entry restores address and code half bit.
// - Optional stack fault reset on overflow or underflow, restarting at zero.
// - Stack fault reset option is enabled after power-on or pin reset.
// - Program counter is 13-bit counter plus separate code half bit.
// - Code half bit loaded only by indirect jump, service entry, interrupt, returns and reset.
module lks_link_stack
  import lks_pkg::*;
#(
  parameter int SLOTS = `LKS_SLOT_COUNT
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        pin_reset,
  input  wire logic        ce_reset,
  input  wire logic        clock_stop,
  // Sequencer command
  input  wire lks_cmd_s    cmd,
  input  wire logic        fault_reset_en_wr,
  input  wire logic        fault_reset_en_val,
  // Register manipulation port
  input  wire lks_reg_s    reg_req,
  output logic      [3:0]  reg_rdata,
  // Program memory port for table reads
  output logic      [13:0] rom_addr,
  input  wire logic [15:0] rom_data,
  // Results
  output logic      [12:0] pc,
  output logic             code_half_select,
  output logic      [15:0] indirect_pointer_word,
  output logic      [15:0] table_buffer,
  output logic      [3:0]  link_level_counter,
  output logic             stack_fault_reset,
  output logic             fault_reset_en,
  output logic             busy
);
  initial begin
    if (SLOTS != 15) $error("lks_link_stack supports fifteen slots only");
  end

  // ========================================
  // Sequencer state
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_POPW  = 4'b0010,
    ST_TBL   = 4'b0100,
    ST_TBLR  = 4'b1000
  } lks_state_e;
  lks_state_e state_reg;
  lks_op_e    pend_reg;

  logic [3:0]  level_reg;
  logic [3:0]  level_next;
  logic [12:0] pc_reg;
  logic        half_reg;
  logic [15:0] ptr_reg;
  logic [15:0] tbuf_reg;
  logic        fault_en_reg;
  logic        fault_reg;
  logic        ce_s1_reg, ce_s2_reg, pin_s1_reg, pin_s2_reg, stop_s1_reg, stop_s2_reg;
  logic        slot_wr;
  logic [15:0] slot_wdata;
  logic [15:0] slot_rdata;
  logic        any_reset;

  function automatic logic is_push(input lks_op_e op);
    return op inside {LKS_OP_CALL, LKS_OP_PUSH, LKS_OP_SVC, LKS_OP_INTR, LKS_OP_TABLE};
  endfunction
  function automatic logic is_pop(input lks_op_e op);
    return op inside {LKS_OP_RET, LKS_OP_LEAVE_INTERRUPT, LKS_OP_POP};
  endfunction

  // ========================================
  // Input synchronisers
  always_ff @(posedge clk) begin
    ce_s1_reg   <= ce_reset;
    ce_s2_reg   <= ce_s1_reg;
    pin_s1_reg  <= pin_reset;
    pin_s2_reg  <= pin_s1_reg;
    stop_s1_reg <= clock_stop;
    stop_s2_reg <= stop_s1_reg;
  end

  assign any_reset = !rst_b || pin_s2_reg || ce_s2_reg || fault_reg;
  wire logic idle_go = state_reg == ST_IDLE && !stop_s2_reg && !any_reset;
  wire lks_op_e op = cmd.irq ? LKS_OP_INTR : cmd.op;

  // ========================================
  // Level counter
  always_comb begin
    level_next = level_reg;
    if (reg_req.wr && reg_req.addr == `LKS_LEVEL_ADDR && state_reg == ST_IDLE)
      level_next = reg_req.wdata;
    else if (idle_go && is_push(op))
      level_next = level_reg - 4'h1;
    else if (state_reg == ST_POPW || state_reg == ST_TBLR)
      level_next = level_reg + 4'h1;
  end

  always_ff @(posedge clk) begin
    if (any_reset)
      level_reg <= `LKS_LEVEL_RESET;
    else if (!stop_s2_reg)
      level_reg <= level_next;
  end

  // ========================================
  // Stack fault detection and option
  always_ff @(posedge clk) begin
    if (!rst_b || pin_s2_reg)
      fault_en_reg <= 1'b1;
    else if (fault_reset_en_wr)
      fault_en_reg <= fault_reset_en_val;
  end

  always_ff @(posedge clk) begin
    if (!rst_b || fault_reg)
      fault_reg <= 1'b0;
    else
      fault_reg <= fault_en_reg && !stop_s2_reg && (
        (idle_go && is_push(op) && level_reg == 4'h0) ||
        ((state_reg == ST_POPW || state_reg == ST_TBLR) && level_reg == 4'hf));
  end

  // ========================================
  // Slot writes
  always_comb begin
    slot_wr    = 1'b0;
    slot_wdata = '0;
    if (idle_go) begin
      unique case (op)
        // Every return slot carries the code half, so each exit goes back to the caller's code half
        LKS_OP_CALL, LKS_OP_TABLE: begin
          slot_wr    = 1'b1;
          slot_wdata = {2'b00, half_reg, pc_reg + 13'h1};
        end
        LKS_OP_INTR: begin
          slot_wr    = 1'b1;
          slot_wdata = {2'b00, half_reg, pc_reg};
        end
        LKS_OP_SVC: begin
          slot_wr    = 1'b1;
          slot_wdata = {2'b00, half_reg, pc_reg + 13'h1};
        end
        LKS_OP_PUSH: begin
          slot_wr    = 1'b1;
          slot_wdata = ptr_reg;
        end
        default: begin
          slot_wr    = 1'b0;
          slot_wdata = '0;
        end
      endcase
    end
  end

  lks_slot_mem #(.DEPTH(SLOTS), .WIDTH(`LKS_SLOT_WIDTH)) u_slots (
    .clk     (clk),
    .wr_en   (slot_wr),
    .wr_addr (level_next),
    .wr_data (slot_wdata),
    .rd_addr (level_next),
    .rd_data (slot_rdata)
  );

  // ========================================
  // Sequencer
  always_ff @(posedge clk) begin
    if (any_reset) begin
      state_reg <= ST_IDLE;
      pend_reg  <= LKS_OP_NONE;
    end else if (!stop_s2_reg) begin
      unique case (state_reg)
        ST_IDLE: begin
          pend_reg <= op;
          if (is_pop(op))
            state_reg <= ST_POPW;
          else if (op == LKS_OP_TABLE)
            state_reg <= ST_TBL;
        end
        ST_POPW: state_reg <= ST_IDLE;
        ST_TBL:  state_reg <= ST_TBLR;
        ST_TBLR: state_reg <= ST_IDLE;
      endcase
    end
  end

  // Program counter and code half
  always_ff @(posedge clk) begin
    if (any_reset) begin
      pc_reg   <= `LKS_PC_START;
      half_reg <= 1'b0;
    end else if (idle_go) begin
      unique case (op)
        LKS_OP_JUMP: pc_reg <= {pc_reg[`LKS_PAGE_HI:`LKS_PAGE_LO], cmd.target[10:0]};
        LKS_OP_CALL: pc_reg <= cmd.target;
        LKS_OP_IJUMP: begin
          pc_reg   <= cmd.target;
          half_reg <= cmd.target_half;
        end
        LKS_OP_SVC: begin
          pc_reg   <= cmd.target;
          half_reg <= 1'b1;
        end
        LKS_OP_INTR: begin
          pc_reg   <= cmd.target;
          half_reg <= 1'b0;
        end
        LKS_OP_TABLE, LKS_OP_RET, LKS_OP_LEAVE_INTERRUPT: pc_reg <= pc_reg;
        default: pc_reg <= pc_reg + 13'h1;
      endcase
    end else if (!stop_s2_reg && state_reg == ST_POPW && pend_reg != LKS_OP_POP) begin
      pc_reg   <= slot_rdata[12:0];
      half_reg <= slot_rdata[`LKS_HALF_BIT];
    end else if (!stop_s2_reg && state_reg == ST_TBLR) begin
      pc_reg <= slot_rdata[12:0];
    end
  end

  // Pointer word and table buffer
  always_ff @(posedge clk) begin
    if (!rst_b)
      ptr_reg <= '0;
    else if (!stop_s2_reg && state_reg == ST_POPW && pend_reg == LKS_OP_POP)
      ptr_reg <= slot_rdata;
    else if (idle_go && op == LKS_OP_IJUMP)
      ptr_reg <= ptr_reg;
    else if (idle_go && op == LKS_OP_NONE && cmd.pointer_word != ptr_reg)
      ptr_reg <= cmd.pointer_word;
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      tbuf_reg <= '0;
    else if (!stop_s2_reg && state_reg == ST_TBL)
      tbuf_reg <= rom_data;
  end

  always_ff @(posedge clk) begin
    if (!rst_b)
      reg_rdata <= 4'h0;
    else if (reg_req.rd && reg_req.addr == `LKS_LEVEL_ADDR)
      reg_rdata <= level_reg;
    else
      reg_rdata <= 4'h0;
  end

  assign rom_addr              = ptr_reg[13:0];
  assign pc                    = pc_reg;
  assign code_half_select      = half_reg;
  assign indirect_pointer_word = ptr_reg;
  assign table_buffer          = tbuf_reg;
  assign link_level_counter    = level_reg;
  assign stack_fault_reset     = fault_reg;
  assign fault_reset_en        = fault_en_reg;
  assign busy                  = state_reg != ST_IDLE;

  // ========================================
  // Checks
  chk_reset_level: assert property (@(posedge clk) !rst_b |=> level_reg == 4'hf)
    else $error("level not 1111 after reset");
  chk_push_dec: assert property (@(posedge clk) disable iff (!rst_b)
    idle_go && is_push(op) && !(reg_req.wr && reg_req.addr == `LKS_LEVEL_ADDR) && !stop_s2_reg
    |=> level_reg == $past(level_reg) - 4'h1 || any_reset)
    else $error("push did not decrement level");
  chk_pop_inc: assert property (@(posedge clk) disable iff (!rst_b)
    state_reg == ST_POPW && !stop_s2_reg && !any_reset && !reg_req.wr
    |=> level_reg == $past(level_reg) + 4'h1 || fault_reg)
    else $error("pop did not increment level");
  chk_wrap_pc: assert property (@(posedge clk) disable iff (any_reset)
    idle_go && op == LKS_OP_NONE && pc_reg == `LKS_PC_LAST |=> pc_reg == 13'h0 && half_reg == $past(half_reg))
    else $error("pc wrap left the code half");
  chk_stop_hold: assert property (@(posedge clk) disable iff (any_reset)
    stop_s2_reg |=> $stable(level_reg))
    else $error("level changed while stopped");
  chk_fault_en: assert property (@(posedge clk) !rst_b |=> fault_en_reg)
    else $error("fault option not enabled");
  chk_overflow: assert property (@(posedge clk) disable iff (!rst_b)
    fault_en_reg && idle_go && is_push(op) && level_reg == 4'h0 |=> fault_reg)
    else $error("overflow not flagged");
  chk_fault_pc: assert property (@(posedge clk) disable iff (!rst_b)
    fault_reg |=> pc_reg == 13'h0 && level_reg == 4'hf)
    else $error("fault reset did not restart");
  chk_table_len: assert property (@(posedge clk) disable iff (any_reset || stop_s2_reg)
    state_reg == ST_TBL |=> state_reg == ST_TBLR ##1 state_reg == ST_IDLE)
    else $error("table read sequence broken");
  chk_half_src: assert property (@(posedge clk) disable iff (any_reset)
    $changed(half_reg) |-> $past(state_reg == ST_POPW || any_reset ||
      (idle_go && op inside {LKS_OP_SVC, LKS_OP_IJUMP, LKS_OP_INTR})))
    else $error("code half changed by illegal op");
  cov_call: cover property (@(posedge clk) idle_go && op == LKS_OP_CALL);
  cov_svc_ret: cover property (@(posedge clk) idle_go && op == LKS_OP_SVC ##[1:20] state_reg == ST_POPW);
  cov_table: cover property (@(posedge clk) state_reg == ST_TBLR);
  cov_fault: cover property (@(posedge clk) fault_reg);
endmodule

/* File: hdl/lks_map.svh */
// Offsets, field positions, reset values and widths of the link stack
`ifndef LKS_MAP_SVH
`define LKS_MAP_SVH
`define LKS_LEVEL_ADDR   4'h1
`define LKS_LEVEL_RESET  4'hf
`define LKS_LEVEL_EMPTY  4'hf
`define LKS_PC_WIDTH     13
`define LKS_PC_LAST      13'h1fff
`define LKS_PC_START     13'h0000
`define LKS_SLOT_WIDTH   16
`define LKS_SLOT_COUNT   15
`define LKS_HALF_BIT     13
`define LKS_PAGE_LO      11
`define LKS_PAGE_HI      12
`endif

/* File: hdl/lks_pkg.sv */
// Types shared by the link stack files
package lks_pkg;
  typedef enum logic [10:0] {
    LKS_OP_NONE   = 11'h001,
    LKS_OP_CALL   = 11'h002,
    LKS_OP_RET    = 11'h004,
    LKS_OP_LEAVE_INTERRUPT   = 11'h008,
    LKS_OP_TABLE  = 11'h010,
    LKS_OP_PUSH   = 11'h020,
    LKS_OP_POP    = 11'h040,
    LKS_OP_SVC    = 11'h080,
    LKS_OP_JUMP   = 11'h100,
    LKS_OP_IJUMP  = 11'h200,
    LKS_OP_INTR   = 11'h400
  } lks_op_e;
  typedef struct packed {
    lks_op_e     op;
    logic [12:0] target;
    logic        target_half;
    logic [15:0] pointer_word;
    logic        irq;
  } lks_cmd_s;
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [3:0] addr;
    logic [3:0] wdata;
  } lks_reg_s;
endpackage

/* File: hdl/lks_slot_mem.sv */
// Link slot storage with registered read data
`include "lks_map.svh"
module lks_slot_mem
  import lks_pkg::*;
#(
  parameter int DEPTH = `LKS_SLOT_COUNT,
  parameter int WIDTH = `LKS_SLOT_WIDTH
) (
  // Clock
  input  wire logic             clk,
  // Write port
  input  wire logic             wr_en,
  input  wire logic [3:0]       wr_addr,
  input  wire logic [WIDTH-1:0] wr_data,
  // Read port
  input  wire logic [3:0]       rd_addr,
  output logic      [WIDTH-1:0] rd_data
);
  initial begin
    if (DEPTH > 15 || DEPTH < 1) $error("lks_slot_mem depth out of range");
  end
  logic [WIDTH-1:0] mem [DEPTH];
  // Slot 15 has no storage; writes there are dropped
  always_ff @(posedge clk) begin
    if (wr_en && int'(wr_addr) < DEPTH) mem[wr_addr] <= wr_data;
  end
  always_ff @(posedge clk) begin
    rd_data <= (int'(rd_addr) < DEPTH) ? mem[rd_addr] : '0;
  end
endmodule

/* File: verification/lks_rom_model.sv */
// Program memory model answering table reads
module lks_rom_model (
  // Program memory port
  input  wire logic [13:0] rom_addr,
  output logic      [15:0] rom_data
);
  timeunit 1ns;
  timeprecision 100ps;
  // ==========================================================
  // Combinational word, valid in the same cycle as the address
  assign rom_data = {~rom_addr[7:0], rom_addr[7:0]};
endmodule

/* File: verification/tb_subroutine_link_stack.sv */
// Self-checking bench for the link stack
module tb_subroutine_link_stack
  import lks_pkg::*;
();
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk, rst_b, pin_reset, ce_reset, clock_stop, fen_wr, fen_val;
  lks_cmd_s    cmd;
  lks_reg_s    reg_req;
  logic [3:0]  reg_rdata, level;
  logic [13:0] rom_addr;
  logic [15:0] rom_data, ptr, tbuf, pw;
  logic [12:0] pc;
  logic        half, fault, fen, busy, seen;
  int          n_fail, checked;
  // ==========================================================
  // Design and program memory
  lks_link_stack DUT (.clk(clk), .rst_b(rst_b), .pin_reset(pin_reset), .ce_reset(ce_reset),
    .clock_stop(clock_stop), .cmd(cmd), .fault_reset_en_wr(fen_wr), .fault_reset_en_val(fen_val),
    .reg_req(reg_req), .reg_rdata(reg_rdata), .rom_addr(rom_addr), .rom_data(rom_data), .pc(pc),
    .code_half_select(half), .indirect_pointer_word(ptr), .table_buffer(tbuf),
    .link_level_counter(level), .stack_fault_reset(fault), .fault_reset_en(fen), .busy(busy));
  lks_rom_model rom (.rom_addr(rom_addr), .rom_data(rom_data));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // ==========================================================
  // Tasks
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic op(input lks_op_e o, input logic [12:0] t = 13'h0, input logic h = 1'b0,
                    input logic q = 1'b0);
    int n;
    @(posedge clk);
    cmd <= '{o, t, h, pw, q};
    @(posedge clk);
    cmd <= '{LKS_OP_NONE, 13'h0, 1'b0, pw, 1'b0};
    #1;
    n = 0;
    while (busy !== 1'b0 && n < 10) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask
  task automatic rw(input logic w, input logic r, input logic [3:0] a, input logic [3:0] d);
    @(posedge clk);
    reg_req <= '{w, r, a, d};
    @(posedge clk);
    reg_req <= '0;
    #1;
  endtask
  task automatic set_fen(input logic v);
    @(posedge clk);
    fen_wr  <= 1'b1;
    fen_val <= v;
    @(posedge clk);
    fen_wr  <= 1'b0;
    #1;
  endtask
  task automatic ext_rst(input logic ce);
    @(posedge clk);
    if (ce) ce_reset <= 1'b1;
    else pin_reset <= 1'b1;
    repeat (4) @(posedge clk);
    ce_reset  <= 1'b0;
    pin_reset <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask
  task automatic wrap_up;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================
  // Tests
  initial begin
    rst_b = 1'b0; pin_reset = 1'b0; ce_reset = 1'b0; clock_stop = 1'b0;
    fen_wr = 1'b0; fen_val = 1'b0; pw = 16'h0; reg_req = '0;
    cmd = '{LKS_OP_NONE, 13'h0, 1'b0, 16'h0, 1'b0};
    n_fail = 0; checked = 0; seen = 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    chk(16'(level), 16'hf); chk(16'(pc), 16'h0); chk(16'(half), 16'h0);
    chk(16'(fen), 16'h1);
    rw(1'b0, 1'b1, 4'h1, 4'h0); chk(16'(reg_rdata), 16'hf);
    rw(1'b0, 1'b1, 4'h2, 4'h0); chk(16'(reg_rdata), 16'h0);
    $display("test reset done");
    op(LKS_OP_JUMP, 13'h1fff, 1'b1); chk(16'(half), 16'h0);
    op(LKS_OP_IJUMP, 13'h1fff, 1'b0); chk(16'(pc), 16'h1fff);
    // The idle cycle before the call wraps 1fff to 0000, so the call saves 0001
    op(LKS_OP_CALL, 13'h0100); chk(16'(level), 16'he); chk(16'(pc), 16'h100);
    op(LKS_OP_RET); chk(16'(pc), 16'h1); chk(16'(level), 16'hf);
    chk(16'(half), 16'h0);
    $display("test call done");
    op(LKS_OP_IJUMP, 13'h0020, 1'b1); chk(16'(half), 16'h1);
    op(LKS_OP_CALL, 13'h0100); op(LKS_OP_RET); chk(16'(pc), 16'h22);
    chk(16'(half), 16'h1);
    op(LKS_OP_IJUMP, 13'h0030, 1'b0); chk(16'(half), 16'h0);
    op(LKS_OP_SVC, 13'h0005, 1'b1); chk(16'(level), 16'he); chk(16'(half), 16'h1);
    op(LKS_OP_RET); chk(16'(pc), 16'h32); chk(16'(half), 16'h0);
    chk(16'(level), 16'hf);
    $display("test service done");
    op(LKS_OP_NONE, 13'h000c, 1'b0, 1'b1); chk(16'(level), 16'he); chk(16'(pc), 16'hc);
    op(LKS_OP_LEAVE_INTERRUPT); chk(16'(pc), 16'h33); chk(16'(level), 16'hf);
    $display("test interrupt done");
    pw = 16'ha5c3;
    op(LKS_OP_NONE); chk(ptr, 16'ha5c3);
    op(LKS_OP_PUSH); chk(16'(level), 16'he);
    pw = 16'h1234;
    op(LKS_OP_NONE); chk(ptr, 16'h1234);
    op(LKS_OP_POP); chk(ptr, 16'ha5c3); chk(16'(level), 16'hf);
    $display("test pointer done");
    pw = 16'h0123;
    op(LKS_OP_JUMP, 13'h0400);
    op(LKS_OP_TABLE); chk(tbuf, 16'hdc23); chk(16'(pc), 16'h402);
    chk(16'(level), 16'hf);
    $display("test table done");
    set_fen(1'b0); chk(16'(fen), 16'h0);
    rw(1'b1, 1'b0, 4'h1, 4'h0); chk(16'(level), 16'h0);
    op(LKS_OP_PUSH); chk(16'(level), 16'hf); chk(16'(fault), 16'h0);
    rw(1'b1, 1'b0, 4'h1, 4'h3);
    rw(1'b1, 1'b0, 4'h2, 4'h5); chk(16'(level), 16'h3);
    rw(1'b0, 1'b1, 4'h1, 4'h0); chk(16'(reg_rdata), 16'h3);
    $display("test register done");
    set_fen(1'b1);
    rw(1'b1, 1'b0, 4'h1, 4'h0);
    @(posedge clk);
    cmd <= '{LKS_OP_CALL, 13'h0100, 1'b0, pw, 1'b0};
    @(posedge clk);
    cmd <= '{LKS_OP_NONE, 13'h0, 1'b0, pw, 1'b0};
    #1;
    // Stop one cycle after the pulse, before idle cycles advance the counter again
    for (int i = 0; i < 4 && seen === 1'b0; i++) begin
      if (fault === 1'b1) seen = 1'b1;
      @(posedge clk);
      #1;
    end
    chk(16'(seen), 16'h1);
    chk(16'(pc), 16'h0); chk(16'(level), 16'hf);
    $display("test fault done");
    set_fen(1'b0);
    rw(1'b1, 1'b0, 4'h1, 4'h5);
    ext_rst(1'b1); chk(16'(level), 16'hf); chk(16'(fen), 16'h0);
    rw(1'b1, 1'b0, 4'h1, 4'h5);
    ext_rst(1'b0); chk(16'(level), 16'hf); chk(16'(fen), 16'h1);
    @(posedge clk);
    clock_stop <= 1'b1;
    repeat (3) @(posedge clk);
    op(LKS_OP_CALL, 13'h0100); chk(16'(level), 16'hf);
    @(posedge clk);
    clock_stop <= 1'b0;
    repeat (3) @(posedge clk);
    $display("test reset sources done");
    wrap_up();
  end
  initial begin
    repeat (4000) @(posedge clk);
    n_fail++;
    wrap_up();
  end
endmodule
